/* File: rtc_interrupt_squarewave_update_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_interrupt_squarewave_update_test;
  import rtcisu_pkg::*;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rtcisu_exp_t;
  logic i_clock, i_sys_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [2:0] fire;
  wire [2:0] evt;
  logic [23:0] alarm;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq_n, o_square_out_pin;
  logic o_osc_enable, i_osc_32k, i_main_supply_ok, i_aux_battery_supply, o_update_tick;
  logic [1:0] o_bresp, o_rresp;
  int err_total, total_checks, cyc, nsq, nupd;
  rtcisu_exp_t rq[$];
  logic [1:0] bq[$];
  rtcisu_top u_dut (.i_clock, .i_sys_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_osc_32k, .i_main_supply_ok,
    .i_aux_battery_supply, .i_wakeup_evt(evt[2]), .i_kickstart_evt(evt[1]),
    .i_ram_clear_evt(evt[0]), .i_time_bytes(24'h000000), .o_irq_n, .o_square_out_pin,
    .o_osc_enable, .o_update_tick);
  rtcisu_osc_model u_osc (.i_clock, .i_fire(fire), .o_osc(i_osc_32k), .o_evt(evt));
  // ----------------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_rd(input rtcisu_exp_t e, input logic [31:0] g, input logic [1:0] r);
    total_checks++;
    if (((g ^ e.d) & e.m) !== 32'h0 || r !== e.r) begin
      err_total++;
      $display("mismatch rdata expected %h/%h seen %h/%h", e.d, e.r, g, r);
    end
  endtask : chk_rd
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    bq.push_back(r);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      aw |= o_awready;
      w |= o_wready;
      if (aw) i_awvalid <= 1'b0;
      if (w) i_wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge i_clock); while (!o_bvalid);
    i_bready <= 1'b0;
    @(posedge i_clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    rq.push_back('{d, m, r});
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clock); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clock); while (!o_rvalid);
    i_rready <= 1'b0;
    @(posedge i_clock);
  endtask : rd
  task automatic count_sq(input int n);
    logic prev;
    nsq = 0;
    prev = o_square_out_pin;
    repeat (n) begin
      @(posedge i_clock);
      if (o_square_out_pin && !prev) nsq++;
      prev = o_square_out_pin;
    end
  endtask : count_sq
  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (o_rvalid && i_rready) chk_rd(rq.pop_front(), o_rdata, o_rresp);
    if (o_bvalid && i_bready) chk_rd('{32'h0, 32'h0, bq.pop_front()}, 32'h0, o_bresp);
    if (o_update_tick !== 1'b0) nupd++;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_aux_battery_supply} = 6'h00;
    {i_awaddr, i_araddr, i_wdata, fire} = 51'h0;
    i_wstrb = 4'hf;
    i_main_supply_ok = 1'b1;
    i_sys_rst = 1'b1;
    void'($urandom(32'h5510));
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    rd(OFF_CTRL_A, 32'h20, 32'h7f, RESP_OKAY);
    rd(OFF_CTRL_B, 32'h0, 32'hff, RESP_OKAY);
    rd(OFF_EXT_CTRL, 32'h0, 32'hffffffff, RESP_SLVERR);
    rd(8'h1c, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    alarm = 24'($urandom());
    wr(OFF_ALARM, {8'h00, alarm}, RESP_OKAY);
    rd(OFF_ALARM, {8'h00, alarm}, 32'hffffffff, RESP_OKAY);
    $display("register test done");
    wr(OFF_CTRL_A, 32'h30, RESP_OKAY);
    fire <= 3'h7;
    repeat (4) @(posedge i_clock);
    fire <= 3'h0;
    repeat (8) @(posedge i_clock);
    chk_bit("irq_n", 1'b1, o_irq_n);
    rd(OFF_EXT_FLAGS, 32'h7, 32'h7, RESP_OKAY);
    rd(OFF_EXT_FLAGS, 32'h7, 32'h7, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_EXT_CTRL, 32'h1 << i, RESP_OKAY);
      repeat (4) @(posedge i_clock);
      chk_bit("irq_n", 1'b0, o_irq_n);
      rd(OFF_FLAGS, 32'h80, 32'h80, RESP_OKAY);
      wr(OFF_EXT_FLAGS, ~(32'h1 << i), RESP_OKAY);
      repeat (4) @(posedge i_clock);
      chk_bit("irq_n", 1'b1, o_irq_n);
    end
    rd(OFF_EXT_FLAGS, 32'h0, 32'h7, RESP_OKAY);
    $display("extended flag test done");
    wr(OFF_CTRL_A, 32'h33, RESP_OKAY);
    repeat (3000) @(posedge i_clock);
    rd(OFF_FLAGS, 32'h40, 32'h70, RESP_OKAY);
    rd(OFF_FLAGS, 32'h0, 32'h40, RESP_OKAY);
    wr(OFF_CTRL_B, 32'h40, RESP_OKAY);
    repeat (3000) @(posedge i_clock);
    chk_bit("irq_n", 1'b0, o_irq_n);
    // No transfer yet, so the user copy still reads its reset value
    rd(OFF_TIME, 32'h0, 32'hffffffff, RESP_OKAY);
    rd(OFF_FLAGS, 32'hc0, 32'hc0, RESP_OKAY);
    repeat (4) @(posedge i_clock);
    chk_bit("irq_n", 1'b1, o_irq_n);
    $display("periodic test done");
    wr(OFF_CTRL_B, 32'h08, RESP_OKAY);
    wr(OFF_EXT_CTRL, 32'h08, RESP_OKAY);
    count_sq(3052);
    chk_bit("square fast", 1'b1, nsq inside {[4:6]});
    rd(OFF_FLAGS, 32'h40, 32'h40, RESP_OKAY);
    // Let the supply level pass the synchroniser before counting
    i_main_supply_ok <= 1'b0;
    repeat (4) @(posedge i_clock);
    count_sq(3052);
    chk_bit("square no supply", 1'b1, nsq == 0);
    i_aux_battery_supply <= 1'b1;
    wr(OFF_EXT_CTRL, 32'h18, RESP_OKAY);
    count_sq(3052);
    chk_bit("square aux", 1'b1, nsq inside {[4:6]});
    i_main_supply_ok <= 1'b1;
    wr(OFF_EXT_CTRL, 32'h0, RESP_OKAY);
    count_sq(3052);
    chk_bit("square tap", 1'b1, nsq inside {[1:2]});
    wr(OFF_CTRL_B, 32'h0, RESP_OKAY);
    count_sq(3052);
    chk_bit("square off", 1'b1, nsq == 0 && o_square_out_pin === 1'b0);
    $display("square test done");
    wr(OFF_CTRL_A, 32'h03, RESP_OKAY);
    repeat (4) @(posedge i_clock);
    chk_bit("osc_enable", 1'b0, o_osc_enable);
    wr(OFF_CTRL_A, 32'h63, RESP_OKAY);
    repeat (4) @(posedge i_clock);
    chk_bit("osc_enable", 1'b1, o_osc_enable);
    rd(OFF_FLAGS, 32'h0, 32'h0, RESP_OKAY);
    repeat (3000) @(posedge i_clock);
    rd(OFF_FLAGS, 32'h0, 32'h40, RESP_OKAY);
    $display("divider test done");
    // First transfer is half a second after the chain starts, far past this run
    chk_bit("update_tick", 1'b1, nupd == 0);
    finish_test();
  end
endmodule : rtc_interrupt_squarewave_update_test
`default_nettype wire

/* File: rtcisu_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcisu_checker
  import rtcisu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready
);
  // ----------------------------------------------------------------
  // Bus handshake checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence wr_taken_s;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence rd_taken_s;
    i_arvalid && o_arready;
  endsequence
  wr_answer_a: assert property (wr_taken_s |=> o_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_taken_s |=> o_rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
  rd_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while busy");
  wr_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while busy");
  rd_release_a: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
    else $error("read not released");
  wr_release_a: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready)
    else $error("write not released");
endmodule : rtcisu_checker
bind rtcisu_top rtcisu_checker u_chk (.i_clock, .i_sys_rst, .i_awvalid, .o_awready,
  .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
  .o_rdata, .o_rresp, .o_rvalid, .i_rready);
`default_nettype wire

/* File: rtcisu_div_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rtcisu_div_if;
  import rtcisu_pkg::*;
  logic tick;
  logic run;
  logic [DIV_W-1:0] count;
  modport chain(input tick, input run, output count);
  modport user(output tick, output run, input count);
endinterface : rtcisu_div_if
`default_nettype wire

/* File: rtcisu_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcisu_divider
  import rtcisu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  rtcisu_div_if.chain dif
);
  // Chain held at zero while not running, so the first update
  // lands half a second after the chain is released
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dif.count <= '0;
    end else if (!dif.run) begin
      dif.count <= '0;
    end else if (dif.tick) begin
      dif.count <= dif.count + 1'b1;
    end
  end
endmodule : rtcisu_divider
`default_nettype wire

/* File: rtcisu_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcisu_osc_model (
  input wire logic i_clock,
  input wire logic [2:0] i_fire,
  output var logic o_osc,
  output var logic [2:0] o_evt
);
  // ----------------------------------------------------------------
  // Crystal and event sources
  // ----------------------------------------------------------------
  // Free running, unrelated in phase to the bus clock
  initial begin
    o_osc = 1'b0;
    forever #15259 o_osc = ~o_osc;
  end
  always @(posedge i_clock) o_evt <= i_fire;
endmodule : rtcisu_osc_model
`default_nettype wire

/* File: rtcisu_pkg.sv */
package rtcisu_pkg;
  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_EXT_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_EXT_CTRL = 8'h10;
  localparam logic [7:0] OFF_ALARM = 8'h14;
  localparam logic [7:0] OFF_TIME = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_UIP = 7;
  localparam int CA_DV_LO = 4;
  localparam int CA_RS_LO = 0;
  localparam int CB_SET = 7;
  localparam int CB_PIE = 6;
  localparam int CB_AIE = 5;
  localparam int CB_UIE = 4;
  localparam int CB_SQUARE_OUT_ENABLE = 3;
  localparam int FC_INTERRUPT_SUMMARY_FLAG = 7;
  localparam int FC_PF = 6;
  localparam int FC_AF = 5;
  localparam int FC_UF = 4;
  localparam int EF_WF = 2;
  localparam int EF_KF = 1;
  localparam int EF_RF = 0;
  localparam int EC_ABE = 4;
  localparam int EC_FAST_CLOCK_OUT_SELECT = 3;
  localparam int EC_WIE = 2;
  localparam int EC_KSE = 1;
  localparam int EC_RIE = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] DV_RST = 3'h2;
  localparam logic [3:0] RS_RST = 4'h0;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [23:0] ALARM_RST = 24'h000000;
  // ----------------------------------------------------------------
  // Timing, in oscillator ticks
  // ----------------------------------------------------------------
  localparam int DIV_W = 15;
  localparam int OSC_HZ = 32768;
  localparam int UIP_LEAD_US = 244;
  localparam int UIP_LEAD_TICKS = (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
  localparam logic [DIV_W-1:0] XFER_LAST = 15'h3fff;
  localparam logic [DIV_W-1:0] UIP_START = XFER_LAST - DIV_W'(UIP_LEAD_TICKS - 1);
  localparam logic [1:0] DONT_CARE = 2'h3;

  // Codes 1 and 2 reuse the 256 Hz and 128 Hz taps
  function automatic logic [3:0] tap_index(input logic [3:0] rs);
    tap_index = (rs < 4'h3) ? rs + 4'h5 : rs - 4'h2;
  endfunction : tap_index
endpackage : rtcisu_pkg

/* File: rtcisu_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcisu_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : rtcisu_sync
`default_nettype wire

/* File: rtcisu_top.sv */
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtcisu_top
  import rtcisu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_osc_32k,
  input wire logic i_main_supply_ok,
  input wire logic i_aux_battery_supply,
  input wire logic i_wakeup_evt,
  input wire logic i_kickstart_evt,
  input wire logic i_ram_clear_evt,
  input wire logic [23:0] i_time_bytes,
  output logic o_irq_n,
  output logic o_square_out_pin,
  output logic o_osc_enable,
  output logic o_update_tick
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic osc_s;
  logic main_s;
  logic aux_s;
  logic [2:0] ext_s;

  rtcisu_sync #(.W(6)) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async({i_osc_32k, i_main_supply_ok, i_aux_battery_supply,
              i_wakeup_evt, i_kickstart_evt, i_ram_clear_evt}),
    .o_sync(pins_s)
  );
  assign osc_s = pins_s[5];
  assign main_s = pins_s[4];
  assign aux_s = pins_s[3];
  assign ext_s = pins_s[2:0];

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic [2:0] dv_r;
  logic [3:0] rate_select_r;
  logic set_r;
  logic periodic_int_enable_r;
  logic alarm_int_enable_r;
  logic update_done_int_enable_r;
  logic square_out_enable_r;
  logic wakeup_int_enable_r;
  logic kickstart_int_enable_r;
  logic ram_clear_int_enable_r;
  logic fast_clock_out_select_r;
  logic aux_battery_out_enable_r;
  logic [23:0] alarm_r;
  logic [23:0] user_copy_r;
  logic periodic_flag_r;
  logic alarm_flag_r;
  logic update_done_flag_r;
  logic [2:0] ext_flag_r;
  logic update_pending_flag_r;
  logic interrupt_summary_flag_r;

  logic divider_reset_ctl;
  logic oscillator_on_ctl;
  logic bank_select_ctl;
  assign divider_reset_ctl = dv_r[2];
  assign oscillator_on_ctl = dv_r[1];
  assign bank_select_ctl = dv_r[0];

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  rtcisu_div_if dif ();
  logic osc_d_r;
  logic [DIV_W-1:0] cnt;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= osc_s;
    end
  end

  // Oscillator stopped means no ticks; 11x runs it with chain cleared
  assign dif.tick = oscillator_on_ctl & osc_s & ~osc_d_r;
  assign dif.run = oscillator_on_ctl & ~divider_reset_ctl;
  assign cnt = dif.count;

  rtcisu_divider u_div (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .dif(dif)
  );

  // ----------------------------------------------------------------
  // Update cycle and alarm
  // ----------------------------------------------------------------
  logic xfer;
  logic pend_win;
  logic alarm_hit;

  function automatic logic byte_match(input logic [7:0] a, input logic [7:0] t);
    byte_match = (a[7:6] == DONT_CARE) || (a == t);
  endfunction : byte_match

  assign xfer = dif.run & dif.tick & (cnt == XFER_LAST);
  assign pend_win = dif.run & (cnt >= UIP_START) & (cnt <= XFER_LAST);
  assign alarm_hit = byte_match(alarm_r[7:0], i_time_bytes[7:0])
                   & byte_match(alarm_r[15:8], i_time_bytes[15:8])
                   & byte_match(alarm_r[23:16], i_time_bytes[23:16]);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      update_pending_flag_r <= 1'b0;
      o_update_tick <= 1'b0;
    end else begin
      update_pending_flag_r <= pend_win & ~set_r;
      o_update_tick <= xfer;
    end
  end

  // Internal copy keeps running; only the user view freezes
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      user_copy_r <= '0;
    end else if (xfer && !set_r) begin
      user_copy_r <= i_time_bytes;
    end
  end

  // ----------------------------------------------------------------
  // Periodic tap and square wave
  // ----------------------------------------------------------------
  logic tap;
  logic tap_d_r;
  logic pf_evt;
  logic sq_nxt;

  assign tap = (rate_select_r != 4'h0) & cnt[tap_index(rate_select_r)];

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tap_d_r <= 1'b0;
    end else begin
      tap_d_r <= tap;
    end
  end

  // Fast select never enters here, so the periodic rate keeps the table
  assign pf_evt = tap & ~tap_d_r;

  always_comb begin
    if (!square_out_enable_r) begin
      sq_nxt = 1'b0;
    end else if (!main_s) begin
      sq_nxt = fast_clock_out_select_r & aux_battery_out_enable_r
             & aux_s & osc_s;
    end else if (fast_clock_out_select_r) begin
      sq_nxt = osc_s;
    end else begin
      sq_nxt = tap;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_square_out_pin <= 1'b0;
      o_osc_enable <= 1'b0;
    end else begin
      o_square_out_pin <= sq_nxt;
      o_osc_enable <= oscillator_on_ctl;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have;
  logic w_have;
  logic wr_go;
  logic ar_take;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic bvalid_nxt;
  logic rvalid_nxt;
  logic rd_flags;
  logic [31:0] rd_mux;

  // Extended registers only appear in bank 1
  function automatic logic mapped(input logic [ADDR_W-1:0] a, input logic bank);
    mapped = (a == OFF_CTRL_A) || (a == OFF_CTRL_B) || (a == OFF_FLAGS)
          || (a == OFF_ALARM) || (a == OFF_TIME)
          || (bank && ((a == OFF_EXT_FLAGS) || (a == OFF_EXT_CTRL)));
  endfunction : mapped

  assign aw_have = aw_hold_r | (i_awvalid & o_awready);
  assign w_have = w_hold_r | (i_wvalid & o_wready);
  assign wr_go = aw_have & w_have;
  assign waddr = aw_hold_r ? awaddr_r : i_awaddr;
  assign wdat = w_hold_r ? wdata_r : i_wdata;
  assign wstb = w_hold_r ? wstrb_r : i_wstrb;
  assign bvalid_nxt = wr_go | (o_bvalid & ~i_bready);
  assign ar_take = i_arvalid & o_arready;
  assign rvalid_nxt = ar_take | (o_rvalid & ~i_rready);
  assign rd_flags = ar_take & (i_araddr == OFF_FLAGS);

  always_comb begin
    rd_mux = '0;
    unique case (i_araddr)
      OFF_CTRL_A: rd_mux[7:0] = {update_pending_flag_r, dv_r, rate_select_r};
      OFF_CTRL_B: rd_mux[7:0] = {set_r, periodic_int_enable_r, alarm_int_enable_r,
                                 update_done_int_enable_r, square_out_enable_r, 3'h0};
      OFF_FLAGS: rd_mux[7:0] = {interrupt_summary_flag_r, periodic_flag_r,
                                alarm_flag_r, update_done_flag_r, 4'h0};
      OFF_EXT_FLAGS: rd_mux[2:0] = ext_flag_r;
      OFF_EXT_CTRL: rd_mux[4:0] = {aux_battery_out_enable_r, fast_clock_out_select_r,
                                   wakeup_int_enable_r, kickstart_int_enable_r,
                                   ram_clear_int_enable_r};
      OFF_ALARM: rd_mux[23:0] = alarm_r;
      OFF_TIME: rd_mux[23:0] = user_copy_r;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      aw_hold_r <= aw_have & ~wr_go;
      w_hold_r <= w_have & ~wr_go;
      if (i_awvalid && o_awready) begin
        awaddr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      o_awready <= ~(aw_have & ~wr_go) & ~bvalid_nxt;
      o_wready <= ~(w_have & ~wr_go) & ~bvalid_nxt;
      o_bvalid <= bvalid_nxt;
      if (wr_go) begin
        o_bresp <= mapped(waddr, bank_select_ctl) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else begin
      o_arready <= ~rvalid_nxt;
      o_rvalid <= rvalid_nxt;
      if (ar_take) begin
        // Snapshot stays put in the data register for the whole beat
        if (mapped(i_araddr, bank_select_ctl)) begin
          o_rdata <= rd_mux;
          o_rresp <= RESP_OKAY;
        end else begin
          o_rdata <= '0;
          o_rresp <= RESP_SLVERR;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  logic wr_ok;
  assign wr_ok = wr_go & wstb[0] & mapped(waddr, bank_select_ctl);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dv_r <= DV_RST;
      rate_select_r <= RS_RST;
    end else if (wr_ok && waddr == OFF_CTRL_A) begin
      dv_r <= wdat[CA_DV_LO +: 3];
      rate_select_r <= wdat[CA_RS_LO +: 4];
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      set_r <= CTRL_B_RST[CB_SET];
      periodic_int_enable_r <= CTRL_B_RST[CB_PIE];
      alarm_int_enable_r <= CTRL_B_RST[CB_AIE];
      update_done_int_enable_r <= CTRL_B_RST[CB_UIE];
      square_out_enable_r <= CTRL_B_RST[CB_SQUARE_OUT_ENABLE];
    end else if (wr_ok && waddr == OFF_CTRL_B) begin
      set_r <= wdat[CB_SET];
      periodic_int_enable_r <= wdat[CB_PIE];
      alarm_int_enable_r <= wdat[CB_AIE];
      // Raising set also drops the update-done enable
      update_done_int_enable_r <= wdat[CB_UIE] & ~(wdat[CB_SET] & ~set_r);
      square_out_enable_r <= wdat[CB_SQUARE_OUT_ENABLE];
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aux_battery_out_enable_r <= EXT_CTRL_RST[EC_ABE];
      fast_clock_out_select_r <= EXT_CTRL_RST[EC_FAST_CLOCK_OUT_SELECT];
      wakeup_int_enable_r <= EXT_CTRL_RST[EC_WIE];
      kickstart_int_enable_r <= EXT_CTRL_RST[EC_KSE];
      ram_clear_int_enable_r <= EXT_CTRL_RST[EC_RIE];
    end else if (wr_ok && waddr == OFF_EXT_CTRL) begin
      aux_battery_out_enable_r <= wdat[EC_ABE];
      fast_clock_out_select_r <= wdat[EC_FAST_CLOCK_OUT_SELECT];
      wakeup_int_enable_r <= wdat[EC_WIE];
      kickstart_int_enable_r <= wdat[EC_KSE];
      ram_clear_int_enable_r <= wdat[EC_RIE];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_alarm
      always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          alarm_r[8*g +: 8] <= ALARM_RST[8*g +: 8];
        end else if (wr_go && wstb[g] && waddr == OFF_ALARM) begin
          alarm_r[8*g +: 8] <= wdat[8*g +: 8];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags and interrupt line
  // ----------------------------------------------------------------
  logic [2:0] ext_d_r;
  logic [2:0] ext_evt;
  logic [2:0] ext_keep;
  logic [5:0] act;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_d_r <= '0;
    end else begin
      ext_d_r <= ext_s;
    end
  end
  assign ext_evt = ext_s & ~ext_d_r;

  // Only bits seen set in the snapshot are cleared; a new event wins
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      periodic_flag_r <= 1'b0;
      alarm_flag_r <= 1'b0;
      update_done_flag_r <= 1'b0;
    end else begin
      periodic_flag_r <= (periodic_flag_r & ~rd_flags) | pf_evt;
      alarm_flag_r <= (alarm_flag_r & ~rd_flags) | (xfer & alarm_hit);
      update_done_flag_r <= (update_done_flag_r & ~rd_flags) | xfer;
    end
  end

  assign ext_keep = (wr_ok && waddr == OFF_EXT_FLAGS) ? wdat[2:0] : 3'h7;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_flag_r <= '0;
    end else begin
      ext_flag_r <= (ext_flag_r & ext_keep) | ext_evt;
    end
  end

  assign act = {periodic_flag_r & periodic_int_enable_r,
                alarm_flag_r & alarm_int_enable_r,
                update_done_flag_r & update_done_int_enable_r,
                ext_flag_r[EF_WF] & wakeup_int_enable_r,
                ext_flag_r[EF_KF] & kickstart_int_enable_r,
                ext_flag_r[EF_RF] & ram_clear_int_enable_r};

  // Combined from current flags, so a late enable fires on the next edge
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_n <= 1'b1;
      interrupt_summary_flag_r <= 1'b0;
    end else begin
      o_irq_n <= ~|act;
      interrupt_summary_flag_r <= |act;
    end
  end
endmodule : rtcisu_top
`default_nettype wire
